//--- spm_far.sv
// Behavioural external slave facing the port in master mode
`timescale 1ns/1ps
module spm_far (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic sel,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   int k = 0;
   int idx;
   initial miso = 1'b0;
   initial rx = 8'h00;
   always @(sel) begin
      k = 0;
      // Released line shows the inverse, never a stale bit
      miso = (sel && !cpha) ? tx[7] : ~miso;
   end
   always @(sclk) begin
      if (sel) begin
         if (sclk ^ cpol ^ cpha) begin
            rx = {rx[6:0], mosi};
         end else begin
            k = k + 1;
            idx = 7 - k + cpha;
            miso = (idx >= 0 && idx <= 7) ? tx[idx] : ~miso;
         end
      end
   end
endmodule

//--- spm_pkg.sv
// Register map, field positions and shared helpers for the serial port
package spm_pkg;
   localparam int BYTE_BITS = 8;
   localparam logic [7:0] CTRL_OFFSET = 8'hf8;
   localparam logic [7:0] DATA_OFFSET = 8'hf7;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;
   localparam int DONE_BIT = 7;
   localparam int WRITE_COLLISION_FLAG_BIT = 6;
   localparam int SEL_BIT = 5;
   localparam int MASTER_BIT = 4;
   localparam int CPOL_BIT = 3;
   localparam int CPHA_BIT = 2;
   localparam int RATE_HI_BIT = 1;
   localparam int RATE_LO_BIT = 0;
   // Bit counts and serial clock edges in one byte: eight bits, two edges per bit
   localparam logic [3:0] LAST_BIT = 4'h7;
   localparam logic [3:0] FULL_COUNT = 4'h8;
   localparam logic [3:0] LAST_TOGGLE = 4'hf;

   // Oscillator cycles per serial clock half period: 1,2,4,8 (divide 2,4,8,16)
   function automatic logic [3:0] half_period(input logic [1:0] rate);
      half_period = 4'(1 << rate);
   endfunction
endpackage

//--- spm_port.sv
// Byte-wide full-duplex serial peripheral port, master or slave
`timescale 1ns/1ps
module spm_port (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic ss_n_in,
   input wire logic ss_latch,
   output logic spi_owns_pins
);
   logic [5:0] ctrl;
   logic done_flag;
   logic write_collision_flag_flag;
   logic [7:0] rx_data;
   logic [7:0] sh;
   logic smp;
   logic txbit;
   logic [3:0] bit_cnt;
   logic busy;
   logic [3:0] div_cnt;
   logic sc_d;
   logic ss_d;
   logic [3:0] pins_s;
   logic sc_s;
   logic mosi_s;
   logic miso_s;
   logic ss_s;

   logic interface_select_bit;
   logic master;
   logic cpol;
   logic cpha;
   logic [1:0] rate;
   logic ss_hi;
   logic slv_act;
   logic tick;
   logic lead;
   logic trail;
   logic din;
   logic ss_rise;
   logic done_ev;
   logic in_prog;
   logic wr_data;
   logic wr_ctrl;
   logic rd_data;
   logic start;
   logic [7:0] shifted;
   logic [7:0] next_rx;

   spm_sync #(.WIDTH(4)) u_sync (
      .clock(clock),
      .nrst(nrst),
      .async_in({sclk_in, mosi_in, miso_in, ss_n_in}),
      .sync_out(pins_s)
   );

   assign {sc_s, mosi_s, miso_s, ss_s} = pins_s;
   assign interface_select_bit = ctrl[spm_pkg::SEL_BIT];
   assign master = ctrl[spm_pkg::MASTER_BIT];
   assign cpol = ctrl[spm_pkg::CPOL_BIT];
   assign cpha = ctrl[spm_pkg::CPHA_BIT];
   assign rate = ctrl[spm_pkg::RATE_HI_BIT:spm_pkg::RATE_LO_BIT];

   // Analog use of the select pin reads as deselected
   assign ss_hi = ss_s | ss_latch;
   assign slv_act = interface_select_bit && !master && !ss_hi;
   assign ss_rise = ss_hi && !ss_d;

   assign wr_data = wr && (addr == spm_pkg::DATA_OFFSET);
   assign wr_ctrl = wr && (addr == spm_pkg::CTRL_OFFSET);
   assign rd_data = rd && (addr == spm_pkg::DATA_OFFSET);

   assign tick = busy && (div_cnt == spm_pkg::half_period(rate) - 4'h1);

   // Leading edge leaves the idle level, trailing edge returns to it
   always_comb begin
      lead = 1'b0;
      trail = 1'b0;
      din = mosi_s;
      if (master) begin
         din = miso_s;
         lead = tick && (sclk_out == cpol);
         trail = tick && (sclk_out != cpol);
      end else if (slv_act && (sc_s != sc_d)) begin
         lead = (sc_d == cpol);
         trail = (sc_d != cpol);
      end
   end

   // Phase 0 samples on leading edge; phase 1 samples on trailing edge
   assign shifted = cpha ? {sh[6:0], din} : {sh[6:0], smp};
   assign next_rx = trail ? shifted : sh;
   assign in_prog = busy || (bit_cnt != 4'h0);
   assign start = wr_data && !in_prog && interface_select_bit && master;

   always_comb begin
      done_ev = 1'b0;
      if (master || cpha) begin
         done_ev = trail && (bit_cnt == spm_pkg::LAST_BIT);
      end else if (interface_select_bit) begin
         done_ev = ss_rise && (bit_cnt == spm_pkg::FULL_COUNT);
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sc_d <= 1'b0;
         ss_d <= 1'b1;
      end else begin
         sc_d <= sc_s;
         ss_d <= ss_hi;
      end
   end

   // Control register
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ctrl <= spm_pkg::CTRL_RESET[5:0];
      end else if (wr_ctrl) begin
         ctrl <= wdata[5:0];
      end
   end

   // Status flags; a hardware set wins over a software clear
   always_ff @(posedge clock) begin
      if (!nrst) begin
         done_flag <= 1'b0;
         write_collision_flag_flag <= 1'b0;
      end else begin
         if (done_ev) begin
            done_flag <= 1'b1;
         end else if (rd_data || (wr_ctrl && !wdata[spm_pkg::DONE_BIT])) begin
            done_flag <= 1'b0;
         end
         if (wr_data && in_prog) begin
            write_collision_flag_flag <= 1'b1;
         end else if (wr_ctrl && !wdata[spm_pkg::WRITE_COLLISION_FLAG_BIT]) begin
            write_collision_flag_flag <= 1'b0;
         end
      end
   end

   // Master clock divider and burst
   always_ff @(posedge clock) begin
      if (!nrst) begin
         busy <= 1'b0;
         div_cnt <= 4'h0;
      end else if (start) begin
         busy <= 1'b1;
         div_cnt <= 4'h0;
      end else if (!interface_select_bit || !master || done_ev) begin
         busy <= 1'b0;
         div_cnt <= 4'h0;
      end else if (busy) begin
         div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sclk_out <= 1'b0;
      end else if (!busy) begin
         sclk_out <= cpol;
      end else if (tick) begin
         sclk_out <= !sclk_out;
      end
   end

   // Bit count: slave count resets when deselected
   always_ff @(posedge clock) begin
      if (!nrst) begin
         bit_cnt <= 4'h0;
      end else if (start || done_ev || !interface_select_bit || (!master && ss_hi)) begin
         bit_cnt <= 4'h0;
      end else if (trail) begin
         bit_cnt <= bit_cnt + 4'h1;
      end
   end

   // Shift engine: one register serves both directions
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sh <= spm_pkg::DATA_RESET;
         smp <= 1'b0;
      end else begin
         if (wr_data && !in_prog) begin
            sh <= wdata;
         end else if (trail) begin
            sh <= shifted;
         end
         if (lead && !cpha) begin
            smp <= din;
         end
      end
   end

   // Outgoing bit: phase 1 on leading edge, phase 0 ready early, moves on trailing
   always_ff @(posedge clock) begin
      if (!nrst) begin
         txbit <= 1'b0;
      end else if (wr_data && !in_prog) begin
         txbit <= wdata[7];
      end else if (cpha && lead) begin
         txbit <= sh[7];
      end else if (!cpha && trail) begin
         txbit <= sh[6];
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         rx_data <= spm_pkg::DATA_RESET;
      end else if (done_ev) begin
         rx_data <= next_rx;
      end
   end

   // Pin direction; slave only drives its data line while selected
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sclk_oe <= 1'b0;
         mosi_oe <= 1'b0;
         miso_oe <= 1'b0;
         spi_owns_pins <= 1'b0;
      end else begin
         sclk_oe <= interface_select_bit && master;
         mosi_oe <= interface_select_bit && master;
         miso_oe <= slv_act;
         spi_owns_pins <= interface_select_bit;
      end
   end

   assign mosi_out = txbit;
   assign miso_out = txbit;

   // Read port; unmapped addresses read zero
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata <= 8'h00;
      end else if (rd && addr == spm_pkg::CTRL_OFFSET) begin
         rdata <= {done_flag, write_collision_flag_flag, ctrl[5:1], master ? ctrl[0] : ss_hi};
      end else if (rd_data) begin
         rdata <= rx_data;
      end else begin
         rdata <= 8'h00;
      end
   end

   // Checks
   logic [3:0] tgl_cnt;

   always_ff @(posedge clock) begin
      if (!nrst || start) begin
         tgl_cnt <= 4'h0;
      end else if (tick) begin
         tgl_cnt <= tgl_cnt + 4'h1;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   sequence s_start;
      start && (rate == 2'b00) && !wr_ctrl;
   endsequence

   sequence s_fast_burst;
      busy [*8] ##0 (tgl_cnt == 4'h7);
   endsequence

   property p_burst_count;
      done_ev && master |-> tgl_cnt == spm_pkg::LAST_TOGGLE;
   endproperty
   a_burst_count: assert property (p_burst_count) else $error("burst not sixteen edges");

   property p_fast_burst;
      s_start |=> s_fast_burst;
   endproperty
   a_fast_burst: assert property (p_fast_burst) else $error("fast burst timing wrong");

   property p_idle_level;
      !busy && !wr_ctrl |=> busy || (sclk_out == $past(cpol));
   endproperty
   a_idle_level: assert property (p_idle_level) else $error("clock idle level wrong");

   property p_done_set;
      done_ev |=> done_flag && (rx_data == $past(next_rx));
   endproperty
   a_done_set: assert property (p_done_set) else $error("done or data not latched");

   property p_done_read_clear;
      rd_data && !done_ev |=> !done_flag;
   endproperty
   a_done_read_clear: assert property (p_done_read_clear) else $error("read left done");

   property p_collision;
      wr_data && in_prog |=> write_collision_flag_flag && (sh == $past(next_rx));
   endproperty
   a_collision: assert property (p_collision) else $error("collision not flagged");

   property p_rx_hold;
      !done_ev |=> $stable(rx_data);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("data changed mid byte");

   property p_slave_ignore;
      !master && ss_hi && !wr_data |=> $stable(sh) && (bit_cnt == 4'h0);
   endproperty
   a_slave_ignore: assert property (p_slave_ignore) else $error("shift while deselected");

   property p_directions;
      1'b1 |=> (sclk_oe == $past(interface_select_bit && master)) && (mosi_oe == $past(interface_select_bit && master))
         && (miso_oe == $past(slv_act));
   endproperty
   a_directions: assert property (p_directions) else $error("pin direction wrong");

   property p_ss_readback;
      rd && (addr == spm_pkg::CTRL_OFFSET) && !master |=> rdata[0] == $past(ss_hi);
   endproperty
   a_ss_readback: assert property (p_ss_readback) else $error("select level not read");
endmodule

//--- spm_sync.sv
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module spm_sync #(
   parameter int WIDTH = 4
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         meta <= '0;
         sync_out <= '0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

//--- test_spi_master_slave_port.sv
// Self-checking bench for the serial port: registers, master and slave
`timescale 1ns/1ps
module test_spi_master_slave_port;
   localparam logic [7:0] CA = spm_pkg::CTRL_OFFSET;
   localparam logic [7:0] DA = spm_pkg::DATA_OFFSET;
   logic clock = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic s_sclk = 1'b0;
   logic s_mosi = 1'b0;
   logic ss_n = 1'b0;
   logic ss_latch = 1'b0;
   logic far_sel = 1'b0;
   logic prev = 1'b0;
   logic [7:0] far_tx = 8'h00;
   logic [7:0] m_ctl = 8'h00;
   logic [7:0] rdata, far_rx;
   logic sclk_out, sclk_oe, mosi_out, mosi_oe, miso_out, miso_oe, owns, far_miso;
   int fail_count = 0, n_compared = 0, cycles = 0, toggles = 0, bad = 0, gap = 0, hp = 1;
   always #5 clock = ~clock;
   spm_port spm_port_i (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .sclk_in(s_sclk), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
      .mosi_in(s_mosi), .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(far_miso),
      .miso_out(miso_out), .miso_oe(miso_oe), .ss_n_in(ss_n), .ss_latch(ss_latch),
      .spi_owns_pins(owns));
   spm_far spm_far_i (.sclk(sclk_out), .mosi(mosi_out), .cpol(m_ctl[3]), .cpha(m_ctl[2]),
      .sel(far_sel), .tx(far_tx), .miso(far_miso), .rx(far_rx));
   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Edge count and half-period spacing of the driven clock
   always @(posedge clock) begin
      cycles <= cycles + 1;
      prev <= sclk_out;
      gap <= (sclk_out !== prev) ? 1 : gap + 1;
      if (sclk_out !== prev) begin
         toggles <= toggles + 1;
         if (toggles > 0 && gap != hp) bad <= bad + 1;
      end
      if (cycles == 20000) begin
         fail_count = fail_count + 1;
         end_of_test();
      end
   end
   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic t_reset();
      logic [7:0] d;
      rd_reg(CA, d);
      chk("control reset", d, spm_pkg::CTRL_RESET);
      rd_reg(DA, d);
      chk("data reset", d, spm_pkg::DATA_RESET);
      chk("pins", {3'h0, owns, sclk_oe, mosi_oe, miso_oe, sclk_out}, 8'h00);
      wr_reg(8'h10, 8'hff);
      rd_reg(8'h10, d);
      chk("unmapped", d, 8'h00);
      rd_reg(CA, d);
      chk("control kept", d, 8'h00);
   endtask
   task automatic m_xfer(input logic [7:0] ctl, input logic [7:0] b, input logic coll);
      logic [7:0] d;
      int i;
      m_ctl = ctl;
      far_tx = ~b;
      wr_reg(CA, ctl);
      rd_reg(CA, d);
      chk("idle clock", {7'h0, sclk_out}, {7'h0, ctl[3]});
      chk("drive", {4'h0, owns, sclk_oe, mosi_oe, miso_oe}, 8'h0e);
      hp = 1 << ctl[1:0];
      toggles = 0;
      bad = 0;
      far_sel = 1'b1;
      wr_reg(DA, b);
      if (coll) wr_reg(DA, 8'h3c);
      i = 0;
      d = 8'h00;
      while (d[7] !== 1'b1 && i < 100) begin
         rd_reg(CA, d);
         i++;
      end
      far_sel = 1'b0;
      chk("flags", d & 8'hc0, {1'b1, coll, 6'h0});
      chk("clock edges", 8'(toggles), 8'h10);
      chk("half period", 8'(bad), 8'h00);
      chk("far rx", far_rx, b);
      // Synchronised input is too late to trust at the two fastest rates
      if (coll) wr_reg(CA, ctl);
      else begin
         rd_reg(DA, d);
         if (ctl[1]) chk("rx", d, ~b);
      end
      rd_reg(CA, d);
      chk("cleared", d & 8'hc0, 8'h00);
   endtask
   task automatic t_slave();
      logic [7:0] d, got;
      wr_reg(CA, 8'h24);
      ss_n <= 1'b1;
      repeat (4) @(posedge clock);
      rd_reg(CA, d);
      chk("select high", d, 8'h25);
      for (int i = 0; i < 16; i++) begin
         @(posedge clock);
         s_sclk <= ~s_sclk;
         repeat (3) @(posedge clock);
      end
      rd_reg(CA, d);
      chk("ignored", {d[7], 6'h0, miso_oe}, 8'h00);
      @(posedge clock);
      ss_n <= 1'b0;
      ss_latch <= 1'b1;
      rd_reg(CA, d);
      rd_reg(CA, d);
      chk("latch holds select", d, 8'h25);
      @(posedge clock);
      ss_latch <= 1'b0;
      rd_reg(CA, d);
      rd_reg(CA, d);
      chk("select low", d, 8'h24);
      wr_reg(DA, 8'hc3);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clock);
         s_sclk <= 1'b1;
         s_mosi <= 1'(8'h5a >> i);
         repeat (8) @(posedge clock);
         got = {got[6:0], miso_out};
         s_sclk <= 1'b0;
         repeat (7) @(posedge clock);
      end
      s_mosi <= ~s_mosi;
      chk("slave drive", {7'h0, miso_oe}, 8'h01);
      chk("miso byte", got, 8'hc3);
      repeat (6) @(posedge clock);
      rd_reg(CA, d);
      chk("slave done", d & 8'h80, 8'h80);
      rd_reg(DA, d);
      chk("slave rx", d, 8'h5a);
      @(posedge clock);
      ss_n <= 1'b1;
      repeat (6) @(posedge clock);
      chk("released", {7'h0, miso_oe}, 8'h00);
   endtask
   task automatic t_slave0();
      logic [7:0] d, got;
      wr_reg(CA, 8'h28);
      s_sclk <= 1'b1;
      repeat (4) @(posedge clock);
      ss_n <= 1'b0;
      repeat (4) @(posedge clock);
      wr_reg(DA, 8'h4b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge clock);
         s_mosi <= 1'(8'hd2 >> i);
         repeat (8) @(posedge clock);
         got = {got[6:0], miso_out};
         s_sclk <= 1'b0;
         repeat (8) @(posedge clock);
         s_sclk <= 1'b1;
         repeat (7) @(posedge clock);
      end
      chk("slave pins", {4'h0, owns, sclk_oe, mosi_oe, miso_oe}, 8'h09);
      chk("phase 0 byte", got, 8'h4b);
      rd_reg(CA, d);
      chk("held until select", d, 8'h28);
      @(posedge clock);
      ss_n <= 1'b1;
      repeat (6) @(posedge clock);
      rd_reg(CA, d);
      chk("select ends byte", d, 8'ha9);
      rd_reg(DA, d);
      chk("phase 0 rx", d, 8'hd2);
   endtask
   initial begin
      repeat (3) @(posedge clock);
      nrst <= 1'b1;
      t_reset();
      for (int r = 0; r < 4; r++) m_xfer(8'h30 | 8'(r), 8'ha5, 1'b0);
      for (int m = 0; m < 4; m++) m_xfer(8'h32 | 8'(m << 2), 8'h69 ^ 8'(m), 1'b0);
      m_xfer(8'h3b, 8'h96, 1'b1);
      t_slave();
      t_slave0();
      end_of_test();
   end
endmodule
